//--- line_diag_pkg.sv
// Shared constants and types for the per-channel line diagnostics control.
// Assumes a 20 MHz system clock and word-aligned registers on a 32-bit bus.
package line_diag_pkg;

  localparam int CHANNELS = 4;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 1;

  // Register indices inside one channel; byte address is four times the
  // full index, and the channel number sits in index bits 7:6.
  localparam logic [5:0] IDX_PATTERN  = 6'h0A;
  localparam logic [5:0] IDX_LOOPBACK = 6'h0B;
  localparam logic [5:0] IDX_CODE_LEN = 6'h0C;
  localparam logic [5:0] IDX_TX_CODE  = 6'h0D;
  localparam int CH_LSB = 6;

  localparam logic [7:0] RST_PATTERN  = 8'h00;
  localparam logic [7:0] RST_LOOPBACK = 8'h00;
  localparam logic [7:0] RST_CODE_LEN = 8'h01;
  localparam logic [7:0] RST_TX_CODE  = 8'h01;

  // Writable bits; reserved bits are stored as zero and read as zero.
  localparam logic [7:0] MASK_PATTERN  = 8'h7F;
  localparam logic [7:0] MASK_LOOPBACK = 8'h0F;
  localparam logic [7:0] MASK_CODE_LEN = 8'h3F;
  localparam logic [7:0] MASK_TX_CODE  = 8'hFF;

  localparam logic [1:0] PAT_NORMAL   = 2'h0;
  localparam logic [1:0] PAT_ALL_ONES = 2'h1;
  localparam logic [1:0] PAT_PRBS     = 2'h2;
  localparam logic [1:0] PAT_INBAND   = 2'h3;

  localparam logic [2:0] CODE_LEN_MIN = 3'h5;
  localparam logic [19:0] PRBS_SEED   = 20'hFFFFF;

  typedef struct packed {
    logic       reserved;
    logic [1:0] pattern_select;
    logic       pattern_clock_select;
    logic       prbs_invert;
    logic       los_ais_criterion;
    logic       ais_during_los_enable;
    logic       auto_all_ones_enable;
  } pattern_ctrl_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic       auto_remote_loopback_enable;
    logic       remote_loopback_enable;
    logic       analog_loopback_enable;
    logic       digital_loopback_enable;
  } loopback_ctrl_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] tx_inband_code_length;
    logic [1:0] rx_activate_code_length;
    logic [1:0] rx_deactivate_code_length;
  } code_len_ctrl_t;

  typedef struct packed {
    pattern_ctrl_t  pattern;
    loopback_ctrl_t loopback;
    code_len_ctrl_t code_len;
    logic [7:0]     tx_inband_code_value;
  } chan_regs_t;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

//--- line_diag_maintenance_ctrl.sv
// Per-channel diagnostics control: register bank, transmit pattern insertion,
// AIS substitution on the receive outputs and loopback selection.
// Assumes bit-rate enables and receive data come from logic on clock_in;
// only the loss-of-signal inputs arrive from outside and are synchronised.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("bit_fifo needs a power-of-two depth of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;

  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                 (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clock_in) begin
    if (in_valid_in && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
    end else if (in_valid_in && !full) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ptr_q <= '0;
    end else if (out_ready_in && !empty) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // bit_fifo

module line_diag_maintenance_ctrl (
  input  wire logic                                    clock_in,
  input  wire logic                                    rst_n_in,
  input  wire logic [line_diag_pkg::ADDR_W-1:0]        avs_address_in,
  input  wire logic                                    avs_read_in,
  input  wire logic                                    avs_write_in,
  input  wire logic [line_diag_pkg::DATA_W-1:0]        avs_writedata_in,
  input  wire logic [3:0]                              avs_byteenable_in,
  output logic      [line_diag_pkg::DATA_W-1:0]        avs_readdata_out,
  output logic                                         avs_waitrequest_out,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      e1_mode_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      tx_clock_en_in,
  input  wire logic                                    master_clock_en_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      sys_tx_valid_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      sys_tx_data_in,
  output logic      [line_diag_pkg::CHANNELS-1:0]      sys_tx_ready_out,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      los_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      rx_pos_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      rx_neg_in,
  input  wire logic [line_diag_pkg::CHANNELS-1:0]      rx_clk_in,
  output logic      [line_diag_pkg::CHANNELS-1:0]      tx_line_data_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      tx_line_strobe_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      rx_positive_data_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      rx_negative_data_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      rx_clock_out,
  output line_diag_pkg::loopback_ctrl_t [line_diag_pkg::CHANNELS-1:0]
                                                       loopback_out,
  output line_diag_pkg::code_len_ctrl_t [line_diag_pkg::CHANNELS-1:0]
                                                       code_len_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      los_ais_criterion_out,
  output logic      [line_diag_pkg::CHANNELS-1:0]      prbs_detect_invert_out
);
  import line_diag_pkg::*;

  chan_regs_t  regs_q [CHANNELS];
  bus_state_t  bus_state_q;
  logic [7:0]  index;
  logic [1:0]  sel_ch;
  logic [5:0]  sel_off;
  logic [7:0]  read_byte;
  logic        request;

  assign index   = avs_address_in[ADDR_W-1:2];
  assign sel_ch  = index[7:CH_LSB];
  assign sel_off = index[CH_LSB-1:0];
  assign request = avs_read_in | avs_write_in;

  // Every access sees exactly one wait cycle, so the answer is fixed.
  assign avs_waitrequest_out = request && (bus_state_q != BUS_ACK);

  always_comb begin
    read_byte = 8'h00;
    case (sel_off)
      IDX_PATTERN:  read_byte = regs_q[sel_ch].pattern;
      IDX_LOOPBACK: read_byte = regs_q[sel_ch].loopback;
      IDX_CODE_LEN: read_byte = regs_q[sel_ch].code_len;
      IDX_TX_CODE:  read_byte = regs_q[sel_ch].tx_inband_code_value;
      default:      read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_state_q <= BUS_IDLE;
    end else begin
      case (bus_state_q)
        BUS_IDLE: begin
          if (request) begin
            bus_state_q <= BUS_ACK;
          end
        end
        BUS_ACK: bus_state_q <= BUS_IDLE;
        default: bus_state_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= '0;
    end else if (bus_state_q == BUS_IDLE && avs_read_in) begin
      avs_readdata_out <= {{(DATA_W-8){1'b0}}, read_byte};
    end
  end

  // Masking keeps reserved bits at zero even if software ignores them.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < CHANNELS; c++) begin
        regs_q[c].pattern              <= RST_PATTERN;
        regs_q[c].loopback             <= RST_LOOPBACK;
        regs_q[c].code_len             <= RST_CODE_LEN;
        regs_q[c].tx_inband_code_value <= RST_TX_CODE;
      end
    end else if (bus_state_q == BUS_ACK && avs_write_in &&
                 avs_byteenable_in[0]) begin
      case (sel_off)
        IDX_PATTERN:
          regs_q[sel_ch].pattern <= avs_writedata_in[7:0] & MASK_PATTERN;
        IDX_LOOPBACK:
          regs_q[sel_ch].loopback <= avs_writedata_in[7:0] & MASK_LOOPBACK;
        IDX_CODE_LEN:
          regs_q[sel_ch].code_len <= avs_writedata_in[7:0] & MASK_CODE_LEN;
        IDX_TX_CODE:
          regs_q[sel_ch].tx_inband_code_value <=
            avs_writedata_in[7:0] & MASK_TX_CODE;
        default: ;
      endcase
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      pattern_ctrl_t ctrl;
      logic          los_meta_q;
      logic          los_q;
      logic          bit_en;
      logic          pass_data;
      logic          fifo_valid;
      logic          fifo_data;
      logic          fifo_pop;
      logic [19:0]   lfsr_q;
      logic          prbs_fb;
      logic          prbs_bit;
      logic [2:0]    code_ptr_q;
      logic [2:0]    code_top;
      logic          tx_bit;
      logic          line_q;
      logic          strobe_q;
      logic          ais_clk_q;
      logic          rx_pos_q;
      logic          rx_neg_q;
      logic          rx_clk_q;
      logic          ais_active;

      assign ctrl = regs_q[ch].pattern;

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          los_meta_q <= 1'b0;
          los_q      <= 1'b0;
        end else begin
          los_meta_q <= los_in[ch];
          los_q      <= los_meta_q;
        end
      end

      // Pattern timing follows the selected reference; data in the normal pattern
      // rides the channel clock because that select must be 0 for it, while
      // auto all-ones pass-through data follows the select.
      assign bit_en = ctrl.pattern_clock_select ? master_clock_en_in
                                                : tx_clock_en_in[ch];

      // With the automatic option, all ones replace data only during LOS.
      assign pass_data =
        (ctrl.pattern_select == PAT_NORMAL && !ctrl.pattern_clock_select) ||
        (ctrl.pattern_select == PAT_ALL_ONES && ctrl.auto_all_ones_enable &&
         !los_q);

      assign fifo_pop = bit_en && pass_data;

      bit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
      ) u_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (sys_tx_valid_in[ch]),
        .in_data_in    (sys_tx_data_in[ch]),
        .in_ready_out  (sys_tx_ready_out[ch]),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (fifo_pop)
      );

      assign prbs_fb = e1_mode_in[ch] ? (lfsr_q[14] ^ lfsr_q[13])
                                      : (lfsr_q[19] ^ lfsr_q[16]);
      assign prbs_bit = prbs_fb ^ ctrl.prbs_invert;

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          lfsr_q <= PRBS_SEED;
        end else if (lfsr_q == 20'h00000) begin
          lfsr_q <= PRBS_SEED;
        end else if (bit_en && ctrl.pattern_select == PAT_PRBS) begin
          lfsr_q <= {lfsr_q[18:0], prbs_fb};
        end
      end

      assign code_top = CODE_LEN_MIN - 3'h1 +
                        {1'b0, regs_q[ch].code_len.tx_inband_code_length};

      // The code is sent most significant of its N bits first; a length
      // cut below the current bit restarts the word at its new top bit.
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          code_ptr_q <= CODE_LEN_MIN - 3'h1;
        end else if (code_ptr_q > code_top) begin
          code_ptr_q <= code_top;
        end else if (bit_en && ctrl.pattern_select == PAT_INBAND) begin
          code_ptr_q <= (code_ptr_q == 3'h0) ? code_top
                                             : code_ptr_q - 3'h1;
        end
      end

      always_comb begin
        tx_bit = 1'b0;
        case (ctrl.pattern_select)
          PAT_NORMAL:   tx_bit = pass_data & fifo_valid & fifo_data;
          PAT_ALL_ONES: tx_bit = pass_data ? (fifo_valid & fifo_data)
                                           : 1'b1;
          PAT_PRBS:     tx_bit = prbs_bit;
          PAT_INBAND:
            tx_bit = regs_q[ch].tx_inband_code_value[code_ptr_q];
          default:      tx_bit = 1'b0;
        endcase
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          line_q   <= 1'b0;
          strobe_q <= 1'b0;
        end else begin
          strobe_q <= bit_en;
          if (bit_en) begin
            line_q <= tx_bit;
          end
        end
      end

      assign ais_active = ctrl.ais_during_los_enable && los_q;

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ais_clk_q <= 1'b0;
        end else if (master_clock_en_in) begin
          ais_clk_q <= ~ais_clk_q;
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          rx_pos_q <= 1'b0;
          rx_neg_q <= 1'b0;
          rx_clk_q <= 1'b0;
        end else begin
          rx_pos_q <= ais_active ? 1'b1 : rx_pos_in[ch];
          rx_neg_q <= ais_active ? 1'b0 : rx_neg_in[ch];
          rx_clk_q <= ais_active ? ais_clk_q : rx_clk_in[ch];
        end
      end

      assign tx_line_data_out[ch]       = line_q;
      assign tx_line_strobe_out[ch]     = strobe_q;
      assign rx_positive_data_out[ch]   = rx_pos_q;
      assign rx_negative_data_out[ch]   = rx_neg_q;
      assign rx_clock_out[ch]           = rx_clk_q;
      assign loopback_out[ch]           =
        regs_q[ch].loopback;
      assign code_len_out[ch]           = regs_q[ch].code_len;
      assign los_ais_criterion_out[ch]  = ctrl.los_ais_criterion;
      assign prbs_detect_invert_out[ch] = ctrl.prbs_invert;
    end
  endgenerate
endmodule // line_diag_maintenance_ctrl

`default_nettype wire

//--- line_diag_maintenance_ctrl_properties.sv
// Concurrent checks on the ports of the diagnostics control block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module line_diag_maintenance_ctrl_properties (
  input wire logic                            clock_in,
  input wire logic                            rst_n_in,
  input wire logic                            avs_read_in,
  input wire logic                            avs_write_in,
  input wire logic [31:0]                     avs_readdata_out,
  input wire logic                            avs_waitrequest_out,
  input wire logic [3:0]                      tx_clock_en_in,
  input wire logic                            master_clock_en_in,
  input wire logic [3:0]                      los_in,
  input wire logic [3:0]                      rx_pos_in,
  input wire logic [3:0]                      tx_line_strobe_out,
  input wire logic [3:0]                      rx_positive_data_out,
  input wire line_diag_pkg::loopback_ctrl_t [3:0] loopback_out,
  input wire line_diag_pkg::code_len_ctrl_t [3:0] code_len_out
);
  import line_diag_pkg::*;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  logic req;
  assign req = avs_read_in || avs_write_in;
  property p_one_wait;
    req && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait cycle");
  property p_idle_wait;
    avs_waitrequest_out |-> req;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("wait raised without a request");
  property p_rd_upper;
    avs_readdata_out[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read data not zero");
  property p_rd_hold;
    !$stable(avs_readdata_out) |-> $past(avs_read_in);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  // Three quiet LOS samples cover the two-flop synchroniser delay.
  property p_rx_follow;
    !los_in[0] [*3] |=> rx_positive_data_out[0] == $past(rx_pos_in[0]);
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("receive data altered without loss of signal");
  property p_strobe_src;
    tx_line_strobe_out[0] |->
      $past(tx_clock_en_in[0]) || $past(master_clock_en_in);
  endproperty
  a_strobe_src: assert property (p_strobe_src)
    else $error("line strobe without a bit enable");
  property p_loop_chg;
    !$stable(loopback_out) |-> $past(avs_write_in);
  endproperty
  a_loop_chg: assert property (p_loop_chg)
    else $error("loopback controls changed without a write");
  property p_len_chg;
    $changed(code_len_out) |-> $past(avs_write_in, 1);
  endproperty
  a_len_chg: assert property (p_len_chg)
    else $error("code lengths changed without a write");
  property p_rsv_zero;
    loopback_out[3].reserved == 4'h0 && code_len_out[2].reserved == 2'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bits not zero");
  c_wr: cover property (avs_write_in && !avs_waitrequest_out);
  c_rd: cover property (avs_read_in && !avs_waitrequest_out);
  c_los: cover property (los_in[0] [*4]);
endmodule // line_diag_maintenance_ctrl_properties
`default_nettype wire

//--- line_far_end_model.sv
// Far side of the block: bit-rate enables and a receive stream.
// Assumes the block samples these outputs on the same rising edge.
`timescale 1ns/100ps
`default_nettype none
module line_far_end_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  output logic      [3:0] tx_en_out,
  output logic            mclk_en_out,
  output logic      [3:0] rx_pos_out,
  output logic      [3:0] rx_neg_out,
  output logic      [3:0] rx_clk_out
);
  logic [4:0] cnt_q;
  // Rates of 4 and 7 cycles differ, so strobe counts tell the sources apart.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q       <= 5'h00;
      tx_en_out   <= 4'h0;
      mclk_en_out <= 1'b0;
      rx_pos_out  <= 4'h0;
      rx_neg_out  <= 4'hF;
      rx_clk_out  <= 4'h0;
    end else begin
      cnt_q       <= (cnt_q == 5'h1B) ? 5'h00 : cnt_q + 5'h01;
      tx_en_out   <= {4{cnt_q[1:0] == 2'h0}};
      mclk_en_out <= (cnt_q % 5'h07) == 5'h00;
      rx_pos_out  <= ~rx_pos_out;
      rx_neg_out  <= rx_pos_out;
      rx_clk_out  <= cnt_q[3:0];
    end
  end
endmodule // line_far_end_model
`default_nettype wire

//--- line_diag_maintenance_ctrl_test.sv
// Self-checking bench: Avalon register tasks and line stream capture.
// Assumes the far-end model supplies enables and receive data.
`timescale 1ns/100ps
`default_nettype none
module line_diag_maintenance_ctrl_test;
  import line_diag_pkg::*;
  localparam logic [5:0] IDX [4] = '{IDX_PATTERN, IDX_LOOPBACK,
                                     IDX_CODE_LEN, IDX_TX_CODE};
  localparam logic [7:0] RSTV [4] = '{RST_PATTERN, RST_LOOPBACK,
                                      RST_CODE_LEN, RST_TX_CODE};
  localparam logic [7:0] MSK [4] = '{MASK_PATTERN, MASK_LOOPBACK,
                                     MASK_CODE_LEN, MASK_TX_CODE};
  localparam logic [31:0] WORD = 32'h2D0F8B4D;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] avs_address_in = 10'h000;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [3:0] avs_byteenable_in = 4'h0;
  logic avs_waitrequest_out, master_clock_en_in;
  logic [3:0] e1_mode_in = 4'h0, sys_tx_valid_in = 4'h0;
  logic [3:0] sys_tx_data_in = 4'h0, los_in = 4'h0;
  logic [3:0] tx_clock_en_in, rx_pos_in, rx_neg_in, rx_clk_in;
  logic [3:0] sys_tx_ready_out, tx_line_data_out, tx_line_strobe_out;
  logic [3:0] rx_positive_data_out, rx_negative_data_out, rx_clock_out;
  logic [3:0] los_ais_criterion_out, prbs_detect_invert_out;
  loopback_ctrl_t [3:0] loopback_out;
  code_len_ctrl_t [3:0] code_len_out;
  logic [63:0] cv;
  int failures = 0;
  int checks_done = 0;
  always #25 clock_in = ~clock_in;
  line_diag_maintenance_ctrl i_dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .e1_mode_in(e1_mode_in),
    .tx_clock_en_in(tx_clock_en_in), .master_clock_en_in(master_clock_en_in),
    .sys_tx_valid_in(sys_tx_valid_in), .sys_tx_data_in(sys_tx_data_in),
    .sys_tx_ready_out(sys_tx_ready_out), .los_in(los_in),
    .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in), .rx_clk_in(rx_clk_in),
    .tx_line_data_out(tx_line_data_out),
    .tx_line_strobe_out(tx_line_strobe_out),
    .rx_positive_data_out(rx_positive_data_out),
    .rx_negative_data_out(rx_negative_data_out),
    .rx_clock_out(rx_clock_out), .loopback_out(loopback_out),
    .code_len_out(code_len_out),
    .los_ais_criterion_out(los_ais_criterion_out),
    .prbs_detect_invert_out(prbs_detect_invert_out));
  line_far_end_model i_far (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .tx_en_out(tx_clock_en_in), .mclk_en_out(master_clock_en_in),
    .rx_pos_out(rx_pos_in), .rx_neg_out(rx_neg_in), .rx_clk_out(rx_clk_in));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang;
    failures++;
    $display("mismatch wait expected answer seen none");
    give_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Every access returns at a falling edge so its effects have settled.
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge clock_in);
    avs_address_in    <= a;
    avs_writedata_in  <= {24'h000000, d};
    avs_byteenable_in <= be;
    avs_write_in      <= w;
    avs_read_in       <= !w;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (n == 20) hang();
    @(negedge clock_in);
  endtask
  task automatic wr(input int c, input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, {2'(c), i, 2'b00}, d, 4'hF, q);
  endtask
  task automatic rd(input int c, input logic [5:0] i, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, {2'(c), i, 2'b00}, 8'h00, 4'hF, q);
    chk("register", {24'h000000, e}, q);
  endtask
  task automatic cap(input int n);
    int k;
    int m;
    m = 0;
    cv = '0;
    // The first strobe after a write may still carry the old pattern's bit.
    @(posedge clock_in);
    for (k = 0; k < 40 * n && m < n; k++) begin
      @(posedge clock_in);
      if (tx_line_strobe_out[0] === 1'b1) begin
        cv[m] = tx_line_data_out[0];
        m++;
      end
    end
    if (m < n) hang();
  endtask
  initial begin
    int c, r, k, n, t, l, a, b, e, f, j, nl, hit, m2;
    logic [7:0] code;
    logic [31:0] q;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (c = 0; c < 4; c++) for (r = 0; r < 4; r++) begin
      rd(c, IDX[r], RSTV[r]);
    end
    for (c = 0; c < 4; c++) for (r = 0; r < 4; r++) begin
      wr(c, IDX[r], 8'hA5 ^ {2'(c), 2'(r), 2'(c), 2'(r)});
    end
    for (c = 0; c < 4; c++) for (r = 0; r < 4; r++) begin
      rd(c, IDX[r], (8'hA5 ^ {2'(c), 2'(r), 2'(c), 2'(r)}) & MSK[r]);
    end
    acc(1'b1, {2'(0), IDX_TX_CODE, 2'b00}, 8'h00, 4'hE, q);
    rd(0, IDX_TX_CODE, 8'hA5 ^ 8'h33);
    wr(1, 6'h0E, 8'hFF);
    rd(1, 6'h0E, 8'h00);
    $display("test registers done");
    for (b = 0; b < 4; b++) begin
      wr(0, IDX_LOOPBACK, 8'h01 << b);
      chk("loopback", 8'h01 << b, loopback_out[0]);
    end
    wr(0, IDX_CODE_LEN, 8'h1B);
    chk("code lengths", 8'h1B, code_len_out[0]);
    $display("test controls done");
    wr(0, IDX_PATTERN, 8'h10);
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clock_in);
      if (sys_tx_valid_in[0] === 1'b1 && sys_tx_ready_out[0] === 1'b1) n++;
      sys_tx_valid_in[0] <= (k != 39);
      sys_tx_data_in[0]  <= WORD[n[4:0]];
    end
    chk("fifo fill", 32, n);
    chk("fifo ready", 0, sys_tx_ready_out[0]);
    n = 0;
    repeat (70) begin
      @(posedge clock_in);
      if (tx_line_strobe_out[0] === 1'b1) n++;
    end
    chk("master strobes", 10, n);
    cap(8);
    chk("zeros", 0, cv[7:0]);
    wr(0, IDX_PATTERN, 8'h00);
    cap(48);
    f = 0;
    while (f < 8 && cv[f] !== 1'b1) f++;
    chk("normal data", WORD, cv[f+:32]);
    chk("empty fifo", 0, cv[f+32+:8]);
    chk("fifo drained", 1, sys_tx_ready_out[0]);
    $display("test stream done");
    wr(0, IDX_PATTERN, 8'h20);
    cap(16);
    chk("all ones", 16'hFFFF, cv[15:0]);
    n = 0;
    repeat (56) begin
      @(posedge clock_in);
      if (tx_line_strobe_out[0] === 1'b1) n++;
    end
    chk("transmit strobes", 14, n);
    $display("test ones done");
    for (t = 0; t < 4; t++) begin
      @(posedge clock_in);
      e1_mode_in <= {4{t[0]}};
      wr(0, IDX_PATTERN, 8'h44 | {4'h0, t[1], 3'h0});
      chk("criterion", 1, los_ais_criterion_out[0]);
      chk("detect invert", t[1], prbs_detect_invert_out[0]);
      cap(56);
      l = t[0] ? 15 : 20;
      a = t[0] ? 14 : 17;
      b = t[0] ? 1 : 3;
      e = 0;
      f = 0;
      for (n = 24; n < 56; n++) begin
        if ((cv[n] ^ cv[n-l] ^ cv[n-a]) !== t[1]) e++;
        if ((cv[n] ^ cv[n-l] ^ cv[n-b]) !== t[1]) f++;
      end
      chk("prbs", 1, (e == 0 || f == 0) && cv[55:4] != 52'h0
          && cv[55:4] != {52{1'b1}});
    end
    $display("test prbs done");
    for (t = 0; t < 2; t++) begin
      nl = t ? 6 : 8;
      code = t ? 8'hCD : 8'hB4;
      wr(0, IDX_CODE_LEN, {2'b00, 2'(nl - 5), 4'h0});
      wr(0, IDX_TX_CODE, code);
      wr(0, IDX_PATTERN, 8'h60);
      cap(40);
      hit = 0;
      for (k = 8; k < 8 + nl; k++) begin
        m2 = 1;
        for (j = 0; j < 24; j++) if (cv[k+j] !== code[nl-1-j%nl]) m2 = 0;
        if (m2) hit = 1;
      end
      chk("inband code", 1, hit);
    end
    $display("test inband done");
    wr(0, IDX_PATTERN, 8'h23);
    cap(8);
    chk("auto idle", 0, cv[7:0]);
    @(posedge clock_in);
    los_in[0] <= 1'b1;
    repeat (4) @(posedge clock_in);
    e = 0;
    a = 0;
    repeat (8) begin
      @(posedge clock_in);
      if (rx_clock_out[0] === 1'b1) a++;
      if (rx_positive_data_out[0] !== 1'b1) e++;
      if (rx_negative_data_out[0] !== 1'b0) e++;
    end
    chk("ais", 0, e);
    chk("ais clock", 1, a > 0 && a < 8);
    cap(8);
    chk("auto ones", 8'hFF, cv[7:0]);
    wr(0, IDX_PATTERN, 8'h21);
    n = 0;
    @(posedge clock_in);
    repeat (8) begin
      @(posedge clock_in);
      if (rx_positive_data_out[0] === 1'b1) n++;
    end
    chk("no ais", 4, n);
    @(posedge clock_in);
    los_in[0] <= 1'b0;
    $display("test alarms done");
    give_verdict();
  end
endmodule // line_diag_maintenance_ctrl_test
bind line_diag_maintenance_ctrl line_diag_maintenance_ctrl_properties
  i_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .tx_clock_en_in(tx_clock_en_in), .master_clock_en_in(master_clock_en_in),
    .los_in(los_in), .rx_pos_in(rx_pos_in),
    .tx_line_strobe_out(tx_line_strobe_out),
    .rx_positive_data_out(rx_positive_data_out),
    .loopback_out(loopback_out), .code_len_out(code_len_out));
`default_nettype wire
